// ===== rtl/flip_regs.vh
// register map, field layout and constant values of the irq priority block
`ifndef FLIP_REGS_VH
`define FLIP_REGS_VH

// ***********************************************************************
// register indices (8-bit map); the byte address is the index times four
// ***********************************************************************
`define FLIP_IDX_EN_MAIN    10'h0a8
`define FLIP_IDX_EN_EXT     10'h0b1
`define FLIP_IDX_PL_EXT     10'h0b2
`define FLIP_IDX_PH_EXT     10'h0b3
`define FLIP_IDX_PH_MAIN    10'h0b7
`define FLIP_IDX_PL_MAIN    10'h0b8
`define FLIP_IDX_STATUS     10'h0c0
`define FLIP_IDX_MASK       10'h0c1
`define FLIP_IDX_BITOP      10'h0c2
`define FLIP_IDX_STATE      10'h0c3

// byte addresses on the 12-bit bus
`define FLIP_ADDR(i)        {i, 2'b00}

// ***********************************************************************
// field layout
// ***********************************************************************
`define FLIP_BIT_GLOBAL     3'd7
`define FLIP_MASK_MAIN      8'hff
`define FLIP_MASK_LOW7      8'h7f
`define FLIP_MASK_EXT       8'h0d
`define FLIP_MASK_STATUS    8'h07
`define FLIP_RESET_BYTE     8'h00
`define FLIP_BITOP_IDX      7:0
`define FLIP_BITOP_POS      10:8
`define FLIP_BITOP_VAL      11

// status event bits
`define FLIP_EV_TAKEN       0
`define FLIP_EV_BAD_ACK     1
`define FLIP_EV_BAD_RET     2

// ***********************************************************************
// vectors in polling order
// ***********************************************************************
`define FLIP_VEC_PIN0       16'h0003
`define FLIP_VEC_TMR0       16'h000b
`define FLIP_VEC_PIN1       16'h0013
`define FLIP_VEC_TMR1       16'h001b
`define FLIP_VEC_PCA        16'h0033
`define FLIP_VEC_UART0      16'h0023
`define FLIP_VEC_TMR2       16'h002b
`define FLIP_VEC_KEYPAD     16'h003b
`define FLIP_VEC_SPI        16'h004b
`define FLIP_VEC_UART1      16'h0053

`endif

// ===== rtl/flip_arbiter.v
// level-then-polling-order request selector
`timescale 1ns/100ps

module flip_arbiter #(
  parameter NSRC = 10,                      // number of sources
  parameter IW   = 4                        // width of a source index
) (
  // requests and their settings, index 0 polled first
  input  wire [NSRC-1:0]   req,
  input  wire [NSRC-1:0]   en,
  input  wire [2*NSRC-1:0] lvl_flat,
  // selection
  output reg               hit,
  output reg  [IW-1:0]     win_idx,
  output reg  [1:0]        win_lvl
);

  // ***********************************************************************
  // per source qualification
  // ***********************************************************************
  wire [NSRC-1:0] live;                     // enabled and requesting

  genvar g;
  generate
    for (g = 0; g < NSRC; g = g + 1) begin : g_live
      assign live[g] = req[g] & en[g];
    end
  endgenerate

  // ***********************************************************************
  // selection: walk from last to first so equal levels fall to the
  // earlier source in the polling order
  // ***********************************************************************
  integer i;
  always @* begin
    hit     = 1'b0;
    win_idx = {IW{1'b0}};
    win_lvl = 2'b00;
    for (i = NSRC - 1; i >= 0; i = i - 1) begin
      if (live[i] && (!hit || lvl_flat[2*i +: 2] >= win_lvl)) begin
        hit     = 1'b1;
        win_idx = i[IW-1:0];
        win_lvl = lvl_flat[2*i +: 2];
      end
    end
  end

endmodule // flip_arbiter

// ===== rtl/flip_top.v
// four-level interrupt enable and priority controller with an apb slave
`timescale 1ns/100ps
`include "flip_regs.vh"

module flip_top #(
  parameter NSRC = 10                       // sources in polling order
) (
  // clock, reset, enable
  input  wire            clk,
  input  wire            rst_b,
  input  wire            ce,
  // apb slave
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [11:0]     paddr,
  input  wire [31:0]     pwdata,
  output wire [31:0]     prdata,
  output wire            pready,
  output wire            pslverr,
  // peripheral request flags, polling order
  input  wire [NSRC-1:0] src_req,
  // processor core
  input  wire            core_ack,
  input  wire            core_reti,
  output wire            core_irq,
  output wire [15:0]     core_vector,
  output wire [3:0]      core_src,
  output wire [1:0]      core_level,
  // status interrupt
  output wire            irq
);

  // ***********************************************************************
  // state
  // ***********************************************************************
  reg  [7:0]  en_main_reg;                  // global + main enables
  reg  [7:0]  en_ext_reg;                   // extended enables
  reg  [7:0]  pl_main_reg;                  // main low priority bits
  reg  [7:0]  ph_main_reg;                  // main high priority bits
  reg  [7:0]  pl_ext_reg;                   // extended low priority bits
  reg  [7:0]  ph_ext_reg;                   // extended high priority bits
  reg  [7:0]  status_reg;                   // sticky events
  reg  [7:0]  mask_reg;                     // event mask
  reg  [3:0]  insvc_reg;                    // one bit per level in service
  reg         pend_reg;                     // request shown to core
  reg  [15:0] vector_reg;                   // its vector
  reg  [3:0]  src_reg;                      // its source index
  reg  [1:0]  lvl_reg;                      // its level
  reg         irq_reg;                      // status interrupt line
  reg         pready_reg;                   // apb ready
  reg         pslverr_reg;                  // apb error
  reg  [31:0] prdata_reg;                   // apb read data

  // ***********************************************************************
  // apb decode
  // ***********************************************************************
  wire       access  = psel & penable;      // access phase
  wire       commit  = access & pready_reg; // edge where a write lands
  wire       wr      = commit & pwrite;
  wire [9:0] bo_idx  = {2'b00, pwdata[`FLIP_BITOP_IDX]};
  wire [7:0] bo_sel  = 8'h01 << pwdata[`FLIP_BITOP_POS];
  wire       bo_val  = pwdata[`FLIP_BITOP_VAL];

  // address hits
  wire a_en_main = (paddr == `FLIP_ADDR(`FLIP_IDX_EN_MAIN));
  wire a_en_ext  = (paddr == `FLIP_ADDR(`FLIP_IDX_EN_EXT));
  wire a_pl_ext  = (paddr == `FLIP_ADDR(`FLIP_IDX_PL_EXT));
  wire a_ph_ext  = (paddr == `FLIP_ADDR(`FLIP_IDX_PH_EXT));
  wire a_ph_main = (paddr == `FLIP_ADDR(`FLIP_IDX_PH_MAIN));
  wire a_pl_main = (paddr == `FLIP_ADDR(`FLIP_IDX_PL_MAIN));
  wire a_status  = (paddr == `FLIP_ADDR(`FLIP_IDX_STATUS));
  wire a_mask    = (paddr == `FLIP_ADDR(`FLIP_IDX_MASK));
  wire a_bitop   = (paddr == `FLIP_ADDR(`FLIP_IDX_BITOP));
  wire a_state   = (paddr == `FLIP_ADDR(`FLIP_IDX_STATE));
  wire a_any     = a_en_main | a_en_ext | a_pl_ext | a_ph_ext | a_ph_main |
                   a_pl_main | a_status | a_mask | a_bitop | a_state;

  // bit operation targets; high priority registers are byte-only
  wire bo_main   = (bo_idx == `FLIP_IDX_EN_MAIN);
  wire bo_ext    = (bo_idx == `FLIP_IDX_EN_EXT);
  wire bo_plm    = (bo_idx == `FLIP_IDX_PL_MAIN);
  wire bo_ple    = (bo_idx == `FLIP_IDX_PL_EXT);
  wire bo_ok     = bo_main | bo_ext | bo_plm | bo_ple;

  // error: unmapped, read-only target, or bit access where not allowed
  wire bad = !a_any || (pwrite && a_state) ||
             (pwrite && a_bitop && !bo_ok);

  // single bit update of one register byte
  function [7:0] bit_upd;
    input [7:0] old;
    input [7:0] sel;
    input       val;
    begin
      bit_upd = val ? (old | sel) : (old & ~sel);
    end
  endfunction

  // ***********************************************************************
  // next register values; reserved bits are masked off and read as zero
  // ***********************************************************************
  reg [7:0] en_main_next;
  reg [7:0] en_ext_next;
  reg [7:0] pl_main_next;
  reg [7:0] ph_main_next;
  reg [7:0] pl_ext_next;
  reg [7:0] ph_ext_next;
  reg [7:0] mask_next;

  always @* begin
    en_main_next = en_main_reg;
    en_ext_next  = en_ext_reg;
    pl_main_next = pl_main_reg;
    ph_main_next = ph_main_reg;
    pl_ext_next  = pl_ext_reg;
    ph_ext_next  = ph_ext_reg;
    mask_next    = mask_reg;
    if (wr) begin
      // whole byte writes
      if (a_en_main)
        en_main_next = pwdata[7:0] & `FLIP_MASK_MAIN;
      if (a_en_ext)
        en_ext_next  = pwdata[7:0] & `FLIP_MASK_EXT;
      if (a_pl_main)
        pl_main_next = pwdata[7:0] & `FLIP_MASK_LOW7;
      if (a_ph_main)
        ph_main_next = pwdata[7:0] & `FLIP_MASK_LOW7;
      if (a_pl_ext)
        pl_ext_next  = pwdata[7:0] & `FLIP_MASK_EXT;
      if (a_ph_ext)
        ph_ext_next  = pwdata[7:0] & `FLIP_MASK_EXT;
      if (a_mask)
        mask_next    = pwdata[7:0] & `FLIP_MASK_STATUS;
      // single bit writes, only on bit addressable registers
      if (a_bitop && bo_main)
        en_main_next = bit_upd(en_main_reg, bo_sel, bo_val) & `FLIP_MASK_MAIN;
      if (a_bitop && bo_ext)
        en_ext_next  = bit_upd(en_ext_reg, bo_sel, bo_val) & `FLIP_MASK_EXT;
      if (a_bitop && bo_plm)
        pl_main_next = bit_upd(pl_main_reg, bo_sel, bo_val) & `FLIP_MASK_LOW7;
      if (a_bitop && bo_ple)
        pl_ext_next  = bit_upd(pl_ext_reg, bo_sel, bo_val) & `FLIP_MASK_EXT;
    end
  end

  // ***********************************************************************
  // source settings gathered into polling order
  // order: pin0, tmr0, pin1, tmr1, pca, uart0, tmr2, keypad, spi, uart1
  // ***********************************************************************
  wire global_irq_on = en_main_reg[`FLIP_BIT_GLOBAL];

  wire [9:0] src_on = {en_ext_reg[3], en_ext_reg[2], en_ext_reg[0],
                       en_main_reg[5], en_main_reg[4], en_main_reg[6],
                       en_main_reg[3], en_main_reg[2], en_main_reg[1],
                       en_main_reg[0]};
  wire [9:0] prio_lo = {pl_ext_reg[3], pl_ext_reg[2], pl_ext_reg[0],
                        pl_main_reg[5], pl_main_reg[4], pl_main_reg[6],
                        pl_main_reg[3], pl_main_reg[2], pl_main_reg[1],
                        pl_main_reg[0]};
  wire [9:0] prio_hi = {ph_ext_reg[3], ph_ext_reg[2], ph_ext_reg[0],
                        ph_main_reg[5], ph_main_reg[4], ph_main_reg[6],
                        ph_main_reg[3], ph_main_reg[2], ph_main_reg[1],
                        ph_main_reg[0]};

  // two-bit level per source, high bit on top
  wire [2*NSRC-1:0] lvl_flat;
  genvar g;
  generate
    for (g = 0; g < NSRC; g = g + 1) begin : g_lvl
      assign lvl_flat[2*g +: 2] = {prio_hi[g], prio_lo[g]};
    end
  endgenerate

  // global enable gates every source regardless of its own bit
  wire [NSRC-1:0] src_gate = src_on[NSRC-1:0] & {NSRC{global_irq_on}};

  // ***********************************************************************
  // selection
  // ***********************************************************************
  wire       hit;                           // some enabled request
  wire [3:0] win_idx;                       // winner in polling order
  wire [1:0] win_lvl;                       // winner level

  flip_arbiter #(
    .NSRC (NSRC),
    .IW   (4)
  ) u_arb (
    .req      (src_req),
    .en       (src_gate),
    .lvl_flat (lvl_flat),
    .hit      (hit),
    .win_idx  (win_idx),
    .win_lvl  (win_lvl)
  );

  // running level: highest level with a routine in service
  reg [1:0] run_lvl;
  always @* begin
    casez (insvc_reg)
      4'b1???: run_lvl = 2'd3;
      4'b01??: run_lvl = 2'd2;
      4'b001?: run_lvl = 2'd1;
      default: run_lvl = 2'd0;
    endcase
  end
  wire busy = |insvc_reg;

  // preempt only upward; nothing ranks above level 3
  wire admit = hit && (!busy || win_lvl > run_lvl);

  // vector lookup
  reg [15:0] win_vec;
  always @* begin
    case (win_idx)
      4'd0:    win_vec = `FLIP_VEC_PIN0;
      4'd1:    win_vec = `FLIP_VEC_TMR0;
      4'd2:    win_vec = `FLIP_VEC_PIN1;
      4'd3:    win_vec = `FLIP_VEC_TMR1;
      4'd4:    win_vec = `FLIP_VEC_PCA;
      4'd5:    win_vec = `FLIP_VEC_UART0;
      4'd6:    win_vec = `FLIP_VEC_TMR2;
      4'd7:    win_vec = `FLIP_VEC_KEYPAD;
      4'd8:    win_vec = `FLIP_VEC_SPI;
      default: win_vec = `FLIP_VEC_UART1;
    endcase
  end

  // ***********************************************************************
  // in-service tracking and status events
  // ***********************************************************************
  wire take     = core_ack & pend_reg;
  wire bad_ack  = core_ack & ~pend_reg;
  wire bad_ret  = core_reti & ~busy;

  // the return releases the latest, i.e. highest, level first
  reg [3:0] insvc_next;
  always @* begin
    insvc_next = insvc_reg;
    if (core_reti)
      insvc_next[run_lvl] = 1'b0;
    if (take)
      insvc_next[lvl_reg] = 1'b1;
  end

  // events set status; a same-cycle set beats the write-one clear
  wire [7:0] ev = {5'b00000, bad_ret, bad_ack, take};
  wire [7:0] w1c = (wr && a_status) ? pwdata[7:0] : 8'h00;
  wire [7:0] status_next = ((status_reg & ~w1c) | ev) & `FLIP_MASK_STATUS;

  // ***********************************************************************
  // read mux
  // ***********************************************************************
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    if (a_en_main) rd_byte = en_main_reg;
    if (a_en_ext)  rd_byte = en_ext_reg;
    if (a_pl_main) rd_byte = pl_main_reg;
    if (a_ph_main) rd_byte = ph_main_reg;
    if (a_pl_ext)  rd_byte = pl_ext_reg;
    if (a_ph_ext)  rd_byte = ph_ext_reg;
    if (a_status)  rd_byte = status_reg;
    if (a_mask)    rd_byte = mask_reg;
    if (a_state)   rd_byte = {pend_reg, 1'b0, run_lvl, insvc_reg};
  end

  // ***********************************************************************
  // registers; ce low freezes everything
  // ***********************************************************************
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en_main_reg <= `FLIP_RESET_BYTE;
      en_ext_reg  <= `FLIP_RESET_BYTE;
      pl_main_reg <= `FLIP_RESET_BYTE;
      ph_main_reg <= `FLIP_RESET_BYTE;
      pl_ext_reg  <= `FLIP_RESET_BYTE;
      ph_ext_reg  <= `FLIP_RESET_BYTE;
      status_reg  <= `FLIP_RESET_BYTE;
      mask_reg    <= `FLIP_RESET_BYTE;
      insvc_reg   <= 4'h0;
      pend_reg    <= 1'b0;
      vector_reg  <= 16'h0000;
      src_reg     <= 4'h0;
      lvl_reg     <= 2'b00;
      irq_reg     <= 1'b0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else if (ce) begin
      en_main_reg <= en_main_next;
      en_ext_reg  <= en_ext_next;
      pl_main_reg <= pl_main_next;
      ph_main_reg <= ph_main_next;
      pl_ext_reg  <= pl_ext_next;
      ph_ext_reg  <= ph_ext_next;
      mask_reg    <= mask_next;
      status_reg  <= status_next;
      insvc_reg   <= insvc_next;
      // level interrupt follows the updated status and mask together
      irq_reg     <= |(status_next & mask_next);
      // a taken request is withdrawn until in-service has caught up
      pend_reg    <= admit & ~core_ack;
      vector_reg  <= win_vec;
      src_reg     <= win_idx;
      lvl_reg     <= win_lvl;
      // one wait state: ready rises at the edge that ends the first access cycle
      pready_reg  <= access & ~pready_reg;
      if (access && !pready_reg) begin
        pslverr_reg <= bad;
        prdata_reg  <= (pwrite || bad) ? 32'h0000_0000 : {24'h000000, rd_byte};
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  // ***********************************************************************
  // outputs
  // ***********************************************************************
  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign core_irq    = pend_reg;
  assign core_vector = vector_reg;
  assign core_src    = src_reg;
  assign core_level  = lvl_reg;
  assign irq         = irq_reg;

endmodule // flip_top

// ===== bench/flip_properties.sv
// checker of the irq priority block, bound to its top module
`timescale 1ns/100ps
`include "flip_regs.vh"
module flip_props (
  // clock, reset, enable
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        ce,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // core side
  input wire logic        core_ack,
  input wire logic        core_reti,
  input wire logic        core_irq,
  input wire logic [15:0] core_vector,
  input wire logic [3:0]  core_src,
  input wire logic [1:0]  core_level
);
  localparam logic [11:0] A_EM = `FLIP_ADDR(`FLIP_IDX_EN_MAIN);
  localparam logic [11:0] A_BO = `FLIP_ADDR(`FLIP_IDX_BITOP);
  localparam logic [15:0] VT [10] = '{`FLIP_VEC_PIN0, `FLIP_VEC_TMR0, `FLIP_VEC_PIN1,
    `FLIP_VEC_TMR1, `FLIP_VEC_PCA, `FLIP_VEC_UART0, `FLIP_VEC_TMR2, `FLIP_VEC_KEYPAD,
    `FLIP_VEC_SPI, `FLIP_VEC_UART1};
  logic       glb;  // global enable as last written
  logic [3:0] isv;  // in-service levels, one bit each
  logic [1:0] top;  // highest in-service level
  wire        wr = ce && psel && penable && pready && pwrite;
  wire        tk = ce && core_ack && core_irq;
  assign top = isv[3] ? 2'd3 : isv[2] ? 2'd2 : isv[1] ? 2'd1 : 2'd0;
  // return drops the top level first, so ack and return together stay right
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      glb <= 1'b0;
      isv <= 4'h0;
    end else begin
      if (wr && paddr == A_EM) glb <= pwdata[7];
      if (wr && paddr == A_BO && pwdata[10:0] == 11'h7a8) glb <= pwdata[11];
      if (ce) isv <= (isv & ~(core_reti && isv != 4'h0 ? 4'h1 << top : 4'h0))
                     | (tk ? 4'h1 << core_level : 4'h0);
    end
  end
  // ***************************************************************
  // properties
  // ***************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_acc;
    ce && psel && penable && !pready;
  endsequence
  sequence s_ans;
    pready ##1 !pready;
  endsequence
  property p_apb_wait;    s_acc |=> s_ans; endproperty
  property p_err_ready;   pslverr |-> pready; endproperty
  property p_bitop_hi;
    s_acc ##0 (pwrite && paddr == A_BO && pwdata[7:0] == 8'hb7) |=> pslverr;
  endproperty
  property p_global;      !glb |=> !core_irq; endproperty
  property p_top_level;   isv[3] |-> !core_irq; endproperty
  property p_preempt;     core_irq |-> (isv == 4'h0 || core_level > top); endproperty
  property p_ack_drop;    tk |=> !core_irq; endproperty
  property p_vector;      core_irq |-> core_vector == VT[core_src]; endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb answer late or long");
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  a_bitop_hi: assert property (p_bitop_hi) else $error("bit op on high prio taken");
  a_global: assert property (p_global) else $error("request while global off");
  a_top_level: assert property (p_top_level) else $error("level 3 preempted");
  a_preempt: assert property (p_preempt) else $error("preempt by non-higher");
  a_ack_drop: assert property (p_ack_drop) else $error("request kept after ack");
  a_vector: assert property (p_vector) else $error("vector wrong for source");
endmodule // flip_props

bind flip_top flip_props flip_props_i (
  .clk(clk), .rst_b(rst_b), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .core_ack(core_ack), .core_reti(core_reti), .core_irq(core_irq),
  .core_vector(core_vector), .core_src(core_src), .core_level(core_level));

// ===== bench/flip_core_model.sv
// behavioural processor core that takes, records and returns from interrupts
`timescale 1ns/100ps
module flip_core_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // presented request
  input  wire logic        core_irq,
  input  wire logic [15:0] core_vector,
  // bench commands: ack delay, return, stray ack
  input  wire logic [3:0]  dly,
  input  wire logic        ret_req,
  input  wire logic        bad_req,
  // answers to the block
  output logic             core_ack,
  output logic             core_reti,
  // record of what was taken
  output logic [15:0]      last_vec,
  output logic [7:0]       n_taken
);
  logic [3:0] cnt;  // cycles the request has waited
  // ack after dly cycles; a stray ack only when the bench asks for one
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core_ack  <= 1'b0;
      core_reti <= 1'b0;
      cnt       <= 4'h0;
      last_vec  <= 16'h0;
      n_taken   <= 8'h0;
    end else begin
      core_reti <= ret_req;  // every return reported
      core_ack  <= bad_req;
      cnt       <= 4'h0;
      if (core_irq && !core_ack) begin
        if (cnt >= dly) core_ack <= 1'b1;
        else cnt <= cnt + 4'h1;
      end
      // taken at the edge that samples ack with a request shown
      if (core_irq && core_ack) begin
        last_vec <= core_vector;
        n_taken  <= n_taken + 8'h1;
      end
    end
  end
endmodule // flip_core_model

// ===== bench/flip_top_tb_top.sv
// self-checking bench of the irq priority block
`timescale 1ns/100ps
`include "flip_regs.vh"
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin n_fail++; \
  $display("ERROR %s expected %h seen %h", nm, ex, gt); end end
module flip_top_tb_top;
  localparam logic [11:0] A_EM = `FLIP_ADDR(`FLIP_IDX_EN_MAIN);
  localparam logic [11:0] A_EE = `FLIP_ADDR(`FLIP_IDX_EN_EXT);
  localparam logic [11:0] A_LM = `FLIP_ADDR(`FLIP_IDX_PL_MAIN);
  localparam logic [11:0] A_HM = `FLIP_ADDR(`FLIP_IDX_PH_MAIN);
  localparam logic [11:0] A_ST = `FLIP_ADDR(`FLIP_IDX_STATUS);
  localparam logic [11:0] A_MK = `FLIP_ADDR(`FLIP_IDX_MASK);
  localparam logic [11:0] A_BO = `FLIP_ADDR(`FLIP_IDX_BITOP);
  localparam logic [11:0] A_SS = `FLIP_ADDR(`FLIP_IDX_STATE);
  localparam logic [11:0] RA [6] = '{A_EM, A_EE, `FLIP_ADDR(`FLIP_IDX_PL_EXT),
    `FLIP_ADDR(`FLIP_IDX_PH_EXT), A_HM, A_LM};
  localparam logic [7:0]  RM [6] = '{8'hff, 8'h0d, 8'h0d, 8'h0d, 8'h7f, 8'h7f};
  localparam logic [15:0] VT [10] = '{`FLIP_VEC_PIN0, `FLIP_VEC_TMR0, `FLIP_VEC_PIN1,
    `FLIP_VEC_TMR1, `FLIP_VEC_PCA, `FLIP_VEC_UART0, `FLIP_VEC_TMR2, `FLIP_VEC_KEYPAD,
    `FLIP_VEC_SPI, `FLIP_VEC_UART1};
  // bench-driven signals, all set at time zero
  logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [9:0]  src_req = 10'h0;
  logic [3:0]  dly = 4'h0;
  logic        ret_req = 1'b0, bad_req = 1'b0;
  // design and model outputs
  logic [31:0] prdata;
  logic        pready, pslverr, core_ack, core_reti, core_irq, irq, e;
  logic [15:0] core_vector, last_vec;
  logic [3:0]  core_src;
  logic [1:0]  core_level;
  logic [7:0]  n_taken, q;
  int          n_fail, comparisons;

  always #25 clk = ~clk;

  flip_top flip_top_i (.clk(clk), .rst_b(rst_b), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_req(src_req), .core_ack(core_ack),
    .core_reti(core_reti), .core_irq(core_irq), .core_vector(core_vector),
    .core_src(core_src), .core_level(core_level), .irq(irq));
  flip_core_model flip_core_model_i (.clk(clk), .rst_b(rst_b), .core_irq(core_irq),
    .core_vector(core_vector), .dly(dly), .ret_req(ret_req), .bad_req(bad_req),
    .core_ack(core_ack), .core_reti(core_reti), .last_vec(last_vec), .n_taken(n_taken));

  // one apb transfer; holds everything until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [11:0] d);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {20'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      n_fail++;
      wrap_up();
    end
    q = prdata[7:0];
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    apb(1'b0, a, 12'h0);
    `CHK("read data", x, q)
    `CHK("read pslverr", 1'b0, e)
  endtask
  // return from interrupt, one cycle pulse
  task automatic ret();
    @(posedge clk) ret_req <= 1'b1;
    @(posedge clk) ret_req <= 1'b0;
  endtask
  // wait for the next take, check its vector, drop its request
  task automatic serve(input int k, input logic r);
    int n;
    logic [7:0] t;
    t = n_taken;
    n = 0;
    while (n_taken === t && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n >= 100) begin
      n_fail++;
      wrap_up();
    end
    `CHK("taken vector", VT[k], last_vec)
    `CHK("taken source", 4'(k), core_src)
    src_req[k] <= 1'b0;
    if (r) ret();
  endtask
  task wrap_up();
    if (n_fail == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ***************************************************************
  // scenarios
  // ***************************************************************
  initial begin
    int k;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    for (k = 0; k < 6; k++) rd(RA[k], 8'h00);
    for (k = 0; k < 6; k++) begin
      apb(1'b1, RA[k], {4'h0, RM[k]});
      rd(RA[k], RM[k]);
      apb(1'b1, RA[k], 12'h000);
    end
    apb(1'b0, 12'hffc, 12'h0);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 8'h00, q)
    apb(1'b1, A_SS, 12'h000);
    `CHK("state write err", 1'b1, e)
    apb(1'b1, A_BO, 12'h8b8);
    rd(A_LM, 8'h01);
    apb(1'b1, A_BO, 12'h8b7);
    `CHK("bit op err", 1'b1, e)
    rd(A_HM, 8'h00);
    apb(1'b1, A_BO, 12'h0b8);
    rd(A_LM, 8'h00);
    // all sources at level 0, global enable off first
    apb(1'b1, A_EE, 12'h00d);
    apb(1'b1, A_EM, 12'h07e);
    src_req <= 10'h3ff;
    repeat (6) @(posedge clk);
    `CHK("blocked request", 1'b0, core_irq)
    `CHK("blocked takes", 8'h00, n_taken)
    apb(1'b1, A_BO, 12'hfa8);
    for (k = 1; k < 10; k++) serve(k, 1'b1);
    apb(1'b1, A_EM, 12'h0ff);
    serve(0, 1'b1);
    // levels 0..3 on the first four sources, a slow core
    apb(1'b1, A_LM, 12'h00a);
    apb(1'b1, A_HM, 12'h00c);
    dly <= 4'h5;
    src_req <= 10'h00f;
    for (k = 3; k >= 0; k--) serve(k, 1'b1);
    src_req <= 10'h001;
    serve(0, 1'b0);
    @(posedge clk) src_req <= 10'h008;
    serve(3, 1'b0);
    @(posedge clk) src_req <= 10'h004;
    repeat (8) @(posedge clk);
    `CHK("level 3 kept", 1'b0, core_irq)
    rd(A_SS, 8'h39);
    ret();
    serve(2, 1'b1);
    ret();
    // status events, mask and the irq output
    rd(A_ST, 8'h01);
    apb(1'b1, A_ST, 12'h007);
    rd(A_ST, 8'h00);
    apb(1'b1, A_MK, 12'h000);
    @(posedge clk) bad_req <= 1'b1;
    @(posedge clk) bad_req <= 1'b0;
    ret();
    repeat (3) @(posedge clk);
    `CHK("masked irq", 1'b0, irq)
    rd(A_ST, 8'h06);
    apb(1'b1, A_MK, 12'h002);
    @(posedge clk);
    `CHK("unmasked irq", 1'b1, irq)
    apb(1'b1, A_ST, 12'h002);
    @(posedge clk);
    `CHK("cleared irq", 1'b0, irq)
    rd(A_ST, 8'h04);
    wrap_up();
  end

  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
endmodule // flip_top_tb_top
